/* File: pkg/tag_cmd_pkg.sv */
// Purpose: Shared constants for the ASCII tag command link and its host controller.
// Assumes: Byte-wide link; UART bit framing lives outside both ends.
package tag_cmd_pkg;
	// Frame characters
	localparam logic [7:0] LEAD_RD = 8'h12;
	localparam logic [7:0] LEAD_WR = 8'h16;
	localparam logic [7:0] LEAD_TM = 8'h0c;
	localparam logic [7:0] CHR_CR = 8'h0d;
	localparam logic [7:0] CHR_COMMA = 8'h2c;
	localparam logic [7:0] CHR_ZERO = 8'h30;
	localparam logic [7:0] CHR_NINE = 8'h39;
	localparam logic [7:0] CHR_NUL = 8'h00;
	// Serial format of the outside UART
	localparam int LINK_BAUD = 9600;
	localparam int LINK_DATA_BITS = 8;
	localparam int LINK_STOP_BITS = 1;
	localparam bit LINK_PARITY = 1'b0;
	localparam bit LINK_FLOW = 1'b0;
	localparam int CLK_HZ = 25_000_000;
	localparam int LINK_BIT_CYCLES = CLK_HZ / LINK_BAUD;
	// Error causes
	localparam logic [3:0] ERR_NONE = 4'h0;
	localparam logic [3:0] ERR_CHAR = 4'h1;
	localparam logic [3:0] ERR_INCOMPLETE = 4'h2;
	localparam logic [3:0] ERR_RANGE = 4'h3;
	localparam logic [3:0] ERR_COUNT = 4'h4;
	// Decimal and time field layout
	localparam logic [2:0] TOP_DIGIT = 3'h4;
	localparam int TM_FIELDS = 6;
	localparam logic [3:0] TM_LAST_REQ = 4'h4;
	// Host controller registers
	localparam logic [7:0] HREG_TX = 8'h00;
	localparam logic [7:0] HREG_RX = 8'h04;
	localparam logic [7:0] HREG_STAT = 8'h08;
	localparam logic [7:0] HREG_MASK = 8'h0c;
	localparam int ST_RX = 0;
	localparam int ST_EOF = 1;
	localparam int ST_TXE = 2;
	localparam int ST_W = 3;
	localparam logic [2:0] MASK_RST = 3'h0;
endpackage : tag_cmd_pkg

/* File: pkg/tag_link_if.sv */
// Purpose: Byte stream link between host controller and display parser.
// Assumes: Both ends on pclk; a byte moves when valid and ready are high.
// Notes: No clocking block; the bench joins the two ends.
`timescale 1ns/1ns
`default_nettype none
interface tag_link_if;
	logic [7:0] h2d_data;
	logic h2d_valid;
	logic h2d_ready;
	logic [7:0] d2h_data;
	logic d2h_valid;
	logic d2h_ready;
	modport dev (input h2d_data, input h2d_valid, output h2d_ready,
		output d2h_data, output d2h_valid, input d2h_ready);
	modport host (output h2d_data, output h2d_valid, input h2d_ready,
		input d2h_data, input d2h_valid, output d2h_ready);
endinterface : tag_link_if
`default_nettype wire

/* File: rtl/tag_parser_dev.sv */
// Purpose: Display end; parses read, write and time frames, answers reads.
// Assumes: Link bytes come from logic on pclk, so no synchroniser.
// Notes: Writes are staged and committed only at CR, so a bad frame changes nothing.
`timescale 1ns/1ns
`default_nettype none
module tag_parser_dev
	import tag_cmd_pkg::*;
#(
	parameter int NUM_TAGS = 16,
	parameter int STR_LEN = 16,
	parameter int MAX_WR = 8,
	parameter bit [15:0] STR_MASK = 16'h0180
) (
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// Link to host
	tag_link_if.dev link,
	// Panel side tag access
	input wire logic local_we,
	input wire logic [15:0] local_addr,
	input wire logic [15:0] local_data,
	input wire logic [15:0] tag_rd_addr,
	output logic [15:0] tag_rd_data_r,
	// Calendar load
	output logic cal_load_r,
	output logic [7:0] cal_mon_r,
	output logic [7:0] cal_day_r,
	output logic [7:0] cal_year_r,
	output logic [7:0] cal_hour_r,
	output logic [7:0] cal_min_r,
	// Error report
	output logic err_r,
	output logic [3:0] err_code_r
);
	localparam int TW = $clog2(NUM_TAGS);
	typedef enum logic [2:0] {S_IDLE, S_NUM, S_STR, S_TIME, S_DRAIN, S_COMMIT, S_CAL,
		S_REPLY} st_t;
	typedef enum logic [1:0] {P_LEAD, P_VAL, P_SEP} ph_t;

	st_t st_r;
	ph_t ph_r;
	logic h2d_ready_r, d2h_valid_r;
	logic [7:0] d2h_data_r, cmd_r, slen_r, j_r;
	logic [15:0] acc_r, start_r, cur_r, cnt_r;
	logic [3:0] fld_r;
	logic [7:0] nw_r, ci_r;
	logic [2:0] k_r;
	logic lz_r, has_str_r;
	logic [15:0] int_mem [NUM_TAGS];
	logic [7:0] str_mem [NUM_TAGS*STR_LEN];
	logic [15:0] pend [MAX_WR];
	logic [7:0] sbuf [STR_LEN];
	logic [7:0] tf [TM_FIELDS];

	assign link.h2d_ready = h2d_ready_r;
	assign link.d2h_valid = d2h_valid_r;
	assign link.d2h_data = d2h_data_r;

	// Incoming byte decode
	logic take, isdig, can;
	logic [7:0] b;
	logic [15:0] nxt_tag, acc_x10;
	assign b = link.h2d_data;
	assign take = link.h2d_valid & h2d_ready_r;
	assign isdig = (b >= CHR_ZERO) && (b <= CHR_NINE);
	assign acc_x10 = 16'(acc_r * 16'd10 + 16'(b - CHR_ZERO));
	assign nxt_tag = start_r + 16'(nw_r) + 16'd1;
	assign can = ~d2h_valid_r | link.d2h_ready;

	// Decimal digit k of v, k=0 is the units
	function automatic logic [3:0] dec_digit(input logic [15:0] v, input logic [2:0] k);
		logic [15:0] q;
		case (k)
			3'h0: q = v;
			3'h1: q = v / 16'd10;
			3'h2: q = v / 16'd100;
			3'h3: q = v / 16'd1000;
			default: q = v / 16'd10000;
		endcase
		return 4'(q % 16'd10);
	endfunction : dec_digit

	// String tags inside a read range
	function automatic int str_cnt(input logic [15:0] s, input logic [15:0] c);
		int n;
		n = 0;
		for (int i = 0; i < NUM_TAGS; i++) begin
			if (i >= int'(s) && i < int'(s) + int'(c) && STR_MASK[i]) n++;
		end
		return n;
	endfunction : str_cnt

	// Current reply values
	logic [15:0] cur_int;
	logic [7:0] cur_chr;
	logic [3:0] cur_dig;
	logic cur_str;
	assign cur_int = int_mem[cur_r[TW-1:0]];
	assign cur_str = STR_MASK[cur_r[TW-1:0]];
	assign cur_chr = (j_r < 8'(STR_LEN)) ?
		str_mem[int'(cur_r[TW-1:0]) * STR_LEN + int'(j_r)] : CHR_NUL;
	assign cur_dig = dec_digit(cur_int, k_r);

	// Frame parser and reply sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= S_IDLE;
			ph_r <= P_LEAD;
			h2d_ready_r <= 1'b0;
			d2h_valid_r <= 1'b0;
			d2h_data_r <= 8'h00;
			cmd_r <= 8'h00;
			acc_r <= 16'h0000;
			start_r <= 16'h0000;
			cur_r <= 16'h0000;
			cnt_r <= 16'h0000;
			fld_r <= 4'h0;
			nw_r <= 8'h00;
			ci_r <= 8'h00;
			slen_r <= 8'h00;
			j_r <= 8'h00;
			k_r <= 3'h0;
			lz_r <= 1'b1;
			has_str_r <= 1'b0;
			cal_load_r <= 1'b0;
			cal_mon_r <= 8'h00;
			cal_day_r <= 8'h00;
			cal_year_r <= 8'h00;
			cal_hour_r <= 8'h00;
			cal_min_r <= 8'h00;
			err_r <= 1'b0;
			err_code_r <= ERR_NONE;
		end else if (ce) begin
			err_r <= 1'b0;
			cal_load_r <= 1'b0;
			if (link.d2h_ready && d2h_valid_r) d2h_valid_r <= 1'b0;
			case (st_r)
				S_IDLE: begin
					h2d_ready_r <= 1'b1;
					if (take) begin
						cmd_r <= b;
						acc_r <= 16'h0000;
						fld_r <= 4'h0;
						nw_r <= 8'h00;
						slen_r <= 8'h00;
						has_str_r <= 1'b0;
						// Stray bytes between frames are ignored
						if (b == LEAD_RD || b == LEAD_WR) st_r <= S_NUM;
						else if (b == LEAD_TM) st_r <= S_TIME;
					end
				end
				S_NUM: if (take) begin
					if (isdig) begin
						acc_r <= acc_x10;
					end else if (b == CHR_COMMA && fld_r == 4'h0) begin
						start_r <= acc_r;
						acc_r <= 16'h0000;
						fld_r <= 4'h1;
						if (acc_r >= 16'(NUM_TAGS)) begin
							err_r <= 1'b1;
							err_code_r <= ERR_RANGE;
							st_r <= S_DRAIN;
						end else if (cmd_r == LEAD_WR && STR_MASK[acc_r[TW-1:0]]) begin
							has_str_r <= 1'b1;
							st_r <= S_STR;
						end
					end else if (b == CHR_COMMA && cmd_r == LEAD_WR) begin
						// Next value goes to the next tag
						pend[nw_r[$clog2(MAX_WR)-1:0]] <= acc_r;
						nw_r <= nw_r + 8'h01;
						acc_r <= 16'h0000;
						if (nw_r + 8'h01 >= 8'(MAX_WR) || nxt_tag >= 16'(NUM_TAGS)) begin
							err_r <= 1'b1;
							err_code_r <= ERR_RANGE;
							st_r <= S_DRAIN;
						end else if (STR_MASK[nxt_tag[TW-1:0]]) begin
							has_str_r <= 1'b1;
							st_r <= S_STR;
						end
					end else if (b == CHR_CR && fld_r == 4'h1 && cmd_r == LEAD_WR) begin
						// An empty field stores zero
						pend[nw_r[$clog2(MAX_WR)-1:0]] <= acc_r;
						nw_r <= nw_r + 8'h01;
						ci_r <= 8'h00;
						h2d_ready_r <= 1'b0;
						st_r <= S_COMMIT;
					end else if (b == CHR_CR && fld_r == 4'h1 && cmd_r == LEAD_RD) begin
						// Compared by difference so a huge count cannot wrap past the check
						if (acc_r == 16'h0000 || acc_r > 16'(NUM_TAGS) - start_r) begin
							err_r <= 1'b1;
							err_code_r <= ERR_COUNT;
							st_r <= S_IDLE;
						end else if (str_cnt(start_r, acc_r) > 1) begin
							err_r <= 1'b1;
							err_code_r <= ERR_COUNT;
							st_r <= S_IDLE;
						end else begin
							cur_r <= start_r;
							cnt_r <= acc_r;
							ph_r <= P_LEAD;
							h2d_ready_r <= 1'b0;
							st_r <= S_REPLY;
						end
					end else if (b == CHR_CR) begin
						err_r <= 1'b1;
						err_code_r <= ERR_INCOMPLETE;
						st_r <= S_IDLE;
					end else begin
						err_r <= 1'b1;
						err_code_r <= ERR_CHAR;
						st_r <= S_DRAIN;
					end
				end
				S_STR: if (take) begin
					if (b == CHR_CR) begin
						ci_r <= 8'h00;
						h2d_ready_r <= 1'b0;
						st_r <= S_COMMIT;
					end else if (slen_r < 8'(STR_LEN)) begin
						// Commas included; excess dropped
						sbuf[slen_r[$clog2(STR_LEN)-1:0]] <= b;
						slen_r <= slen_r + 8'h01;
					end
				end
				S_TIME: if (take) begin
					if (isdig) begin
						acc_r <= acc_x10;
					end else if (b == CHR_COMMA && fld_r < 4'(TM_FIELDS - 1)) begin
						tf[fld_r[2:0]] <= acc_r[7:0];
						fld_r <= fld_r + 4'h1;
						acc_r <= 16'h0000;
					end else if (b == CHR_CR && fld_r >= TM_LAST_REQ) begin
						tf[fld_r[2:0]] <= acc_r[7:0];
						// Hold the link while the calendar loads
						h2d_ready_r <= 1'b0;
						st_r <= S_CAL;
					end else begin
						err_r <= 1'b1;
						err_code_r <= (b == CHR_CR) ? ERR_INCOMPLETE : ERR_CHAR;
						st_r <= (b == CHR_CR) ? S_IDLE : S_DRAIN;
					end
				end
				S_CAL: begin
					// Seconds are parsed but not applied
					cal_mon_r <= tf[0];
					cal_day_r <= tf[1];
					cal_year_r <= tf[2];
					cal_hour_r <= tf[3];
					cal_min_r <= tf[4];
					cal_load_r <= 1'b1;
					st_r <= S_IDLE;
				end
				S_DRAIN: if (take && b == CHR_CR) st_r <= S_IDLE;
				S_COMMIT: begin
					if (ci_r < nw_r) ci_r <= ci_r + 8'h01;
					else st_r <= S_IDLE;
				end
				S_REPLY: if (can) begin
					case (ph_r)
						P_LEAD: begin
							d2h_data_r <= LEAD_RD;
							d2h_valid_r <= 1'b1;
							ph_r <= P_VAL;
							k_r <= TOP_DIGIT;
							j_r <= 8'h00;
							lz_r <= 1'b1;
						end
						P_VAL: begin
							if (cur_str) begin
								if (cur_chr == CHR_NUL) begin
									ph_r <= P_SEP;
								end else begin
									d2h_data_r <= cur_chr;
									d2h_valid_r <= 1'b1;
									j_r <= j_r + 8'h01;
								end
							end else begin
								// Leading zeros skipped, units always sent
								if (!(cur_dig == 4'h0 && lz_r && k_r != 3'h0)) begin
									d2h_data_r <= CHR_ZERO + 8'(cur_dig);
									d2h_valid_r <= 1'b1;
									lz_r <= 1'b0;
								end
								if (k_r == 3'h0) ph_r <= P_SEP;
								else k_r <= k_r - 3'h1;
							end
						end
						default: begin
							d2h_valid_r <= 1'b1;
							if (cnt_r == 16'h0001) begin
								d2h_data_r <= CHR_CR;
								st_r <= S_IDLE;
							end else begin
								d2h_data_r <= CHR_COMMA;
								cur_r <= cur_r + 16'h0001;
								cnt_r <= cnt_r - 16'h0001;
								ph_r <= P_VAL;
								k_r <= TOP_DIGIT;
								j_r <= 8'h00;
								lz_r <= 1'b1;
							end
						end
					endcase
				end
				default: st_r <= S_IDLE;
			endcase
		end
	end

	// Tag storage; commit beats a panel write to the same tag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_TAGS; i++) int_mem[i] <= 16'h0000;
			for (int i = 0; i < NUM_TAGS * STR_LEN; i++) str_mem[i] <= CHR_NUL;
			tag_rd_data_r <= 16'h0000;
		end else if (ce) begin
			tag_rd_data_r <= int_mem[tag_rd_addr[TW-1:0]];
			if (local_we && local_addr < 16'(NUM_TAGS)) int_mem[local_addr[TW-1:0]] <= local_data;
			if (st_r == S_COMMIT) begin
				if (ci_r < nw_r) begin
					int_mem[TW'(start_r + 16'(ci_r))] <= pend[ci_r[$clog2(MAX_WR)-1:0]];
				end else if (has_str_r) begin
					// Bytes past the text are nulled
					for (int j = 0; j < STR_LEN; j++) begin
						str_mem[int'(TW'(start_r + 16'(nw_r))) * STR_LEN + j] <=
							(j < int'(slen_r)) ? sbuf[j] : CHR_NUL;
					end
				end
			end
		end
	end
endmodule : tag_parser_dev
`default_nettype wire

/* File: rtl/tag_host_ctrl.sv */
// Purpose: Host end; software sends and receives link bytes over APB.
// Assumes: Software builds frames and keeps the host-side framing limits.
// Notes: A TX write stalls pready until the previous byte has left.
`timescale 1ns/1ns
`default_nettype none
module tag_host_ctrl
	import tag_cmd_pkg::*;
(
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata_r,
	output logic pready_r,
	output logic pslverr_r,
	// Interrupt
	output logic irq_r,
	// Link to display
	tag_link_if.host link
);
	logic h2d_valid_r, d2h_ready_r, rx_full_r;
	logic [7:0] h2d_data_r, rx_byte_r;
	logic [ST_W-1:0] stat_r, mask_r, set_ev;
	logic access, done, tx_hit, rx_take, tx_take, mapped, rx_pop;

	// Both ends share one byte format on the link
	assign link.h2d_valid = h2d_valid_r;
	assign link.h2d_data = h2d_data_r;
	assign link.d2h_ready = d2h_ready_r;

	assign access = psel & penable & ~pready_r;
	assign done = psel & penable & pready_r;
	assign tx_hit = pwrite & (paddr == HREG_TX);
	assign mapped = (paddr == HREG_TX) | (paddr == HREG_RX) | (paddr == HREG_STAT) |
		(paddr == HREG_MASK);
	assign rx_take = link.d2h_valid & d2h_ready_r;
	assign tx_take = h2d_valid_r & link.h2d_ready;
	// Pop only a byte that this read really returned; a late arrival stays put
	assign rx_pop = done & ~pwrite & (paddr == HREG_RX) & prdata_r[8];
	// Link events for the sticky status
	assign set_ev = {tx_take, rx_take & (link.d2h_data == CHR_CR), rx_take};

	// APB answer; one wait state, more for a TX write while a TX byte is pending
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else if (ce) begin
			pready_r <= access & ~(tx_hit & h2d_valid_r);
			pslverr_r <= access & ~mapped;
			case (paddr)
				HREG_TX: prdata_r <= {24'h00_0000, h2d_data_r};
				HREG_RX: prdata_r <= {23'h0, rx_full_r, rx_byte_r};
				HREG_STAT: prdata_r <= {29'h0, stat_r};
				HREG_MASK: prdata_r <= {29'h0, mask_r};
				default: prdata_r <= 32'h0000_0000;
			endcase
		end
	end

	// Outgoing byte; software frames per the display's rules
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			h2d_valid_r <= 1'b0;
			h2d_data_r <= 8'h00;
		end else if (ce) begin
			if (done && tx_hit) begin
				h2d_data_r <= pwdata[7:0];
				h2d_valid_r <= 1'b1;
			end else if (tx_take) begin
				h2d_valid_r <= 1'b0;
			end
		end
	end

	// Incoming byte holding register, popped by an RX read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_full_r <= 1'b0;
			rx_byte_r <= 8'h00;
			d2h_ready_r <= 1'b0;
		end else if (ce) begin
			if (rx_take) begin
				rx_byte_r <= link.d2h_data;
				rx_full_r <= 1'b1;
			end else if (rx_pop) begin
				rx_full_r <= 1'b0;
			end
			d2h_ready_r <= ~(rx_take | (rx_full_r & ~rx_pop));
		end
	end

	// Sticky status, mask and interrupt; a new event beats the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_r <= 3'h0;
			mask_r <= MASK_RST;
			irq_r <= 1'b0;
		end else if (ce) begin
			if (done && pwrite && paddr == HREG_STAT) stat_r <= (stat_r & ~pwdata[ST_W-1:0]) | set_ev;
			else stat_r <= stat_r | set_ev;
			if (done && pwrite && paddr == HREG_MASK) mask_r <= pwdata[ST_W-1:0];
			irq_r <= |(stat_r & mask_r);
		end
	end
endmodule : tag_host_ctrl
`default_nettype wire

/* File: tb/tag_link_chk.sv */
// Purpose: Watches the byte link between the two ends for framing and handshake slips.
// Assumes: Both ends on pclk with ce held high.
// Notes: The lead tracker is fooled by a lead byte inside a string; tests avoid that.
`timescale 1ns/1ns
`default_nettype none
module tag_link_chk
	import tag_cmd_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Host to device
	input wire logic [7:0] h2d_data,
	input wire logic h2d_valid,
	input wire logic h2d_ready,
	// Device to host
	input wire logic [7:0] d2h_data,
	input wire logic d2h_valid,
	input wire logic d2h_ready
);
	logic in_reply_r;
	logic [7:0] cmd_r;
	wire logic h_xfer;
	wire logic d_xfer;
	assign h_xfer = h2d_valid & h2d_ready;
	assign d_xfer = d2h_valid & d2h_ready;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Reply tracker; a CR byte closes the frame
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_reply_r <= 1'b0;
		end else if (d_xfer) begin
			in_reply_r <= (d2h_data != CHR_CR);
		end
	end
	// Last command lead seen from the host
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_r <= 8'h00;
		end else if (h_xfer && (h2d_data == LEAD_RD || h2d_data == LEAD_WR || h2d_data == LEAD_TM)) begin
			cmd_r <= h2d_data;
		end
	end
	a_d2h_hold: assert property (d2h_valid && !d2h_ready |=> d2h_valid && $stable(d2h_data))
		else $error("reply byte changed before it was taken");
	a_h2d_hold: assert property (h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data))
		else $error("command byte changed before it was taken");
	a_reply_lead: assert property (d_xfer && !in_reply_r |-> d2h_data == LEAD_RD)
		else $error("reply frame opened without read lead");
	a_reply_source: assert property (d2h_valid && !in_reply_r |-> cmd_r == LEAD_RD)
		else $error("reply offered without a read command");
	a_reply_gap: assert property (d_xfer && d2h_data == CHR_CR |=> !d2h_valid [*3])
		else $error("second reply frame followed at once");
	a_host_pulse: assert property (h_xfer |=> !h2d_valid)
		else $error("host repeated a byte after hand-over");
	a_reply_ends: assert property ($rose(in_reply_r) |-> ##[1:1000] !in_reply_r)
		else $error("reply frame never closed with CR");
	a_ready_back: assert property ($fell(h2d_ready) && cmd_r != LEAD_RD |-> ##[1:20] h2d_ready)
		else $error("link stayed blocked after commit");
	// Main scenarios
	c_reply_done: cover property (d_xfer && d2h_data == CHR_CR);
	c_commit: cover property ($fell(h2d_ready) && cmd_r == LEAD_WR);
	c_h2d_stall: cover property (h2d_valid && !h2d_ready);
endmodule : tag_link_chk
`default_nettype wire

/* File: tb/tb_ascii_tag_command_parser.sv */
// Purpose: Drives frames through the host end over APB and checks the display end.
// Assumes: Tags 7 and 8 are strings of 16 bytes; ce held high throughout.
// Notes: Expected bytes are queued before each frame so early replies are not missed.
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin logic [63:0] g_, e_; g_ = 64'(got); e_ = 64'(exp); \
	tests_run++; if (g_ !== e_) begin errors++; \
	$display("unexpected at %0t: got %0h expected %0h", $time, g_, e_); end end
module tb_ascii_tag_command_parser
	import tag_cmd_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic local_we = 1'b0;
	logic [15:0] local_addr = 16'h0;
	logic [15:0] local_data = 16'h0;
	logic [15:0] tag_rd_addr = 16'h0;
	logic [31:0] prdata_r;
	logic pready_r, pslverr_r, irq_r, last_err, cal_load_r, err_r;
	logic [15:0] tag_rd_data_r;
	logic [7:0] cal_mon_r, cal_day_r, cal_year_r, cal_hour_r, cal_min_r;
	logic [3:0] err_code_r;
	logic [7:0] exp_q[$];
	logic [39:0] cal_q[$];
	logic [3:0] err_q[$];
	int errors = 0;
	int tests_run = 0;
	tag_link_if link();
	tag_parser_dev tag_parser_dev_i (.pclk(pclk), .presetn(presetn), .ce(1'b1), .link(link),
		.local_we(local_we), .local_addr(local_addr), .local_data(local_data),
		.tag_rd_addr(tag_rd_addr), .tag_rd_data_r(tag_rd_data_r), .cal_load_r(cal_load_r),
		.cal_mon_r(cal_mon_r), .cal_day_r(cal_day_r), .cal_year_r(cal_year_r),
		.cal_hour_r(cal_hour_r), .cal_min_r(cal_min_r), .err_r(err_r), .err_code_r(err_code_r));
	tag_host_ctrl tag_host_ctrl_i (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r),
		.pready_r(pready_r), .pslverr_r(pslverr_r), .irq_r(irq_r), .link(link));
	tag_link_chk tag_link_chk_i (.pclk(pclk), .presetn(presetn), .h2d_data(link.h2d_data),
		.h2d_valid(link.h2d_valid), .h2d_ready(link.h2d_ready), .d2h_data(link.d2h_data),
		.d2h_valid(link.d2h_valid), .d2h_ready(link.d2h_ready));
	// 25 MHz clock
	always #20 pclk = ~pclk;
	// Verdict and end of run
	task automatic results();
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : results
	// One APB transfer; waits on pready, only the watchdog ends a hang
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready_r !== 1'b1);
		q = prdata_r;
		last_err = pslverr_r;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Lead, body bytes and closing CR, one TX write each
	task automatic frame(input logic [7:0] lead, input string body);
		logic [31:0] q;
		apb(1'b1, HREG_TX, {24'h0, lead}, q);
		foreach (body[i]) apb(1'b1, HREG_TX, {24'h0, body[i]}, q);
		apb(1'b1, HREG_TX, {24'h0, CHR_CR}, q);
	endtask : frame
	// Read request; reply noted first, then popped from RX until all bytes came
	task automatic rd(input string req, input string rsp);
		logic [31:0] q;
		int got, k;
		got = 0;
		k = 0;
		exp_q.push_back(LEAD_RD);
		foreach (rsp[i]) exp_q.push_back(rsp[i]);
		exp_q.push_back(CHR_CR);
		frame(LEAD_RD, req);
		while (got < rsp.len() + 2 && k < 400) begin
			apb(1'b0, HREG_RX, 32'h0, q);
			if (q[8] === 1'b1) got++;
			k++;
		end
		`CHK(got, rsp.len() + 2)
	endtask : rd
	// Commit takes nw+1 cycles after CR, then the tag view lags one cycle
	task automatic tag_is(input logic [15:0] a, input logic [15:0] e);
		repeat (12) @(posedge pclk);
		tag_rd_addr <= a;
		repeat (2) @(posedge pclk);
		`CHK(tag_rd_data_r, e)
	endtask : tag_is
	// Result watcher: every reply byte, calendar load and error is matched to a note
	always @(posedge pclk) begin
		if (link.d2h_valid === 1'b1 && link.d2h_ready === 1'b1) begin
			if (exp_q.size() > 0) `CHK(link.d2h_data, exp_q.pop_front())
			else `CHK(1'b0, 1'b1)
		end
		if (cal_load_r === 1'b1) begin
			if (cal_q.size() > 0)
				`CHK({cal_mon_r, cal_day_r, cal_year_r, cal_hour_r, cal_min_r}, cal_q.pop_front())
			else `CHK(1'b0, 1'b1)
		end
		if (err_r === 1'b1) begin
			if (err_q.size() > 0) `CHK(err_code_r, err_q.pop_front())
			else `CHK(1'b0, 1'b1)
		end
	end
	// Watchdog, well above the expected run length
	initial begin
		repeat (80000) @(posedge pclk);
		errors++;
		results();
	end
	initial begin
		logic [31:0] q;
		logic [15:0] v;
		void'($urandom(32'h0db8));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		// Multi write; string swallows commas and is cut at its size
		frame(LEAD_WR, "5,25,8888,NEW TEXT, STOP,40");
		tag_is(16'd5, 16'd25);
		tag_is(16'd6, 16'd8888);
		rd("7,1", "NEW TEXT, STOP,4");
		rd("8,1", "");
		rd("5,2", "25,8888");
		$display("test 1 done");
		// Zero an integer, null a string
		frame(LEAD_WR, "5,0");
		tag_is(16'd5, 16'd0);
		frame(LEAD_WR, "7,");
		rd("7,1", "");
		$display("test 2 done");
		// Time set with and without seconds
		cal_q.push_back({8'd8, 8'd7, 8'd96, 8'd2, 8'd55});
		frame(LEAD_TM, "08,07,96,02,55");
		cal_q.push_back({8'd12, 8'd31, 8'd99, 8'd23, 8'd59});
		frame(LEAD_TM, "12,31,99,23,59,30");
		repeat (4) @(posedge pclk);
		`CHK(cal_q.size(), 0)
		$display("test 3 done");
		// Bad frames: no change, cause reported
		err_q.push_back(ERR_CHAR);
		frame(LEAD_WR, "5,x9");
		tag_is(16'd5, 16'd0);
		err_q.push_back(ERR_INCOMPLETE);
		frame(LEAD_RD, "3");
		err_q.push_back(ERR_COUNT);
		frame(LEAD_RD, "7,2");
		repeat (4) @(posedge pclk);
		`CHK(err_q.size(), 0)
		$display("test 4 done");
		// Random values from link and panel, read back as decimal
		for (int k = 0; k < 3; k++) begin
			v = 16'($urandom);
			frame(LEAD_WR, $sformatf("9,%0d", v));
			tag_is(16'd9, v);
			rd("9,1", $sformatf("%0d", v));
			local_addr <= 16'd3;
			local_data <= v ^ 16'h5a5a;
			local_we <= 1'b1;
			@(posedge pclk);
			local_we <= 1'b0;
			rd("3,1", $sformatf("%0d", v ^ 16'h5a5a));
		end
		$display("test 5 done");
		// Interrupt on byte sent, then cleared; unmapped address refused
		apb(1'b1, HREG_MASK, 32'h4, q);
		repeat (2) @(posedge pclk);
		`CHK(irq_r, 1'b1)
		apb(1'b1, HREG_STAT, 32'h7, q);
		repeat (2) @(posedge pclk);
		`CHK(irq_r, 1'b0)
		apb(1'b0, 8'h10, 32'h0, q);
		`CHK(last_err, 1'b1)
		$display("test 6 done");
		results();
	end
endmodule : tb_ascii_tag_command_parser
`default_nettype wire
